// [hw/dtc_pkg.sv]
// Shared constants and types for the display timing and clock sync block
package dtc_pkg;
    // Synchronisation modes
    typedef enum logic [1:0] {
        DTC_SYNC_FREE_RUN,
        DTC_SYNC_FRAME,
        DTC_SYNC_RSVD_A,
        DTC_SYNC_RSVD_B
    } dtc_sync_mode_t;

    // Pixel formats
    localparam logic DTC_FMT_18 = 1'b0;
    localparam logic DTC_FMT_24 = 1'b1;
    localparam int   DTC_PIX_W  = 24;
    localparam int   DTC_PIX18_W = 18;
    localparam int   DTC_CH18_W = 6;
    localparam int   DTC_CH24_W = 8;

    // Counter and control widths
    localparam int   DTC_CNT_W   = 12;
    localparam int   DTC_FCW_W   = 30;
    localparam int   DTC_RATE_W  = 8;

    // Display clock range limits in kHz
    localparam int   DTC_DISPLAY_PIXEL_CLOCK_MIN_KHZ = 10000;
    localparam int   DTC_DISPLAY_PIXEL_CLOCK_MAX_KHZ = 135000;

    // Reset values
    localparam logic [DTC_CNT_W-1:0]  DTC_CNT_RST  = 12'h000;
    localparam logic [DTC_FCW_W-1:0]  DTC_FCW_RST  = 30'h0000_0000;
    localparam logic [DTC_RATE_W-1:0] DTC_RATE_ONE = 8'h01;
endpackage : dtc_pkg

// [hw/dtc_sync2.sv]
// Two-flop synchroniser with edge detection on the second stage
`timescale 1ns/1ns
`default_nettype none
module dtc_sync2
    import dtc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_b_in,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out,
    output logic      [WIDTH-1:0] rise_out,
    output logic      [WIDTH-1:0] fall_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    // Meta stage feeds only the second flop
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign sync_out = sync_q;
    assign rise_out = sync_q & ~prev_q;
    assign fall_out = ~sync_q & prev_q;
endmodule : dtc_sync2
`default_nettype wire

// [hw/dtc_display_clock_synthesizer.sv]
// Display clock synthesizer: phase accumulator, open or closed loop
`timescale 1ns/1ns
`default_nettype none
module dtc_display_clock_synthesizer
    import dtc_pkg::*;
#(
    parameter int FCW_W = DTC_FCW_W
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_b_in,
    // Control
    input  wire logic             closed_loop_in,
    input  wire logic [FCW_W-1:0] open_fcw_in,
    input  wire logic [FCW_W-1:0] closed_fcw_in,
    // Result
    output logic                  pix_tick_out,
    output logic      [FCW_W-1:0] fcw_out
);
    logic [FCW_W-1:0] acc_q;
    logic [FCW_W:0]   sum;
    logic [FCW_W-1:0] fcw_q;

    // Loop select, registered
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            fcw_q <= DTC_FCW_RST;
        end else begin
            fcw_q <= closed_loop_in ? closed_fcw_in : open_fcw_in;
        end
    end

    assign sum = {1'b0, acc_q} + {1'b0, fcw_q};

    // Carry out marks one display pixel period
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            acc_q        <= DTC_FCW_RST;
            pix_tick_out <= 1'b0;
        end else begin
            acc_q        <= sum[FCW_W-1:0];
            pix_tick_out <= sum[FCW_W];
        end
    end

    assign fcw_out = fcw_q;
endmodule : dtc_display_clock_synthesizer
`default_nettype wire

// [hw/dtc_display_timing.sv]
// Display timing generator with synthesizer control and frame lock
//
// Summary of operation
// - Output is 18- or 24-bit RGB, one or two pixels per output clock.
// - Every pixel word and timing output leaves on the display pixel clock edge.
// - The synthesizer runs either open loop or closed loop through a ratio detector.
// - Open loop uses only the reference and a 30-bit frequency control word.
// - Synthesizer, multiplier and divider together reach 10 MHz to 135 MHz.
// - Closed loop sets display clock to input clock times display/source totals and M/N.
// - Free-run takes timing from programmed values only, open loop, no frame lock; an enabled manual sync still reloads the counters.
// - Frame sync reloads the counters with lock-load values at the lock-event position.
// - Without rate conversion the reload may occur once per input frame.
// - With rate conversion the reload occurs once every N input frames.
// - With manual sync enabled, a falling edge of the manual frame sync forces the lock-load values.
// - Sync and data-enable positions and widths come from programmed values.
// - Horizontal counts are pixels from hsync lead, vertical counts lines from vsync lead.
// - Double-wide output is valid only with even horizontal counts.
`timescale 1ns/1ns
`default_nettype none
module dtc_display_timing
    import dtc_pkg::*;
#(
    parameter int CNT_W  = DTC_CNT_W,
    parameter int FCW_W  = DTC_FCW_W,
    parameter int RATE_W = DTC_RATE_W
) (
    // Clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_b_in,
    // Mode control
    input  wire dtc_sync_mode_t        sync_mode_in,
    input  wire logic                  manual_sync_en_in,
    input  wire logic                  frc_en_in,
    input  wire logic [RATE_W-1:0]     lock_every_n_in,
    input  wire logic                  fmt_24_in,
    input  wire logic                  double_wide_in,
    // Synthesizer control
    input  wire logic [FCW_W-1:0]      open_fcw_in,
    input  wire logic [RATE_W-1:0]     rate_m_in,
    input  wire logic [RATE_W-1:0]     rate_n_in,
    input  wire logic [CNT_W-1:0]      source_line_total_in,
    input  wire logic [CNT_W-1:0]      source_frame_lines_in,
    // Display timing values
    input  wire logic [CNT_W-1:0]      display_line_total_in,
    input  wire logic [CNT_W-1:0]      display_frame_lines_in,
    input  wire logic [CNT_W-1:0]      hsync_width_in,
    input  wire logic [CNT_W-1:0]      h_active_start_in,
    input  wire logic [CNT_W-1:0]      h_active_end_in,
    input  wire logic [CNT_W-1:0]      vsync_width_in,
    input  wire logic [CNT_W-1:0]      v_active_start_in,
    input  wire logic [CNT_W-1:0]      v_active_end_in,
    // Lock event and lock load
    input  wire logic [CNT_W-1:0]      lock_event_h_in,
    input  wire logic [CNT_W-1:0]      lock_event_v_in,
    input  wire logic [CNT_W-1:0]      lock_load_h_in,
    input  wire logic [CNT_W-1:0]      lock_load_v_in,
    // Input timing from the source side
    input  wire logic                  input_pixel_clock_in,
    input  wire logic                  input_hsync_in,
    input  wire logic                  input_vsync_in,
    input  wire logic                  manual_frame_sync_n_in,
    // Pixel data
    input  wire logic [DTC_PIX_W-1:0]  pixel_a_in,
    input  wire logic [DTC_PIX_W-1:0]  pixel_b_in,
    // Display port
    output logic                       display_pixel_clock_out,
    output logic                       display_hsync_out,
    output logic                       display_vsync_out,
    output logic                       display_data_enable_out,
    output logic [DTC_PIX_W-1:0]       display_data_a_out,
    output logic [DTC_PIX_W-1:0]       display_data_b_out,
    // Status
    output logic                       double_wide_ok_out,
    output logic                       lock_applied_out,
    output logic [FCW_W-1:0]           active_fcw_out
);
    localparam int PROD_W = 2 * CNT_W + RATE_W;

    if (CNT_W < 4 || CNT_W > 16 || FCW_W != DTC_FCW_W || RATE_W < 1 || RATE_W > 12) begin : g_chk
        $error("dtc_display_timing: unsupported parameters");
    end

    // Input pixel clock and source timing cross into core domain
    logic input_pixel_clock_rise;
    logic ip_hs_rise;
    logic ip_vs_rise;
    logic man_fall;
    logic [3:0] sync_lvl;
    logic [3:0] sync_rise;
    logic [3:0] sync_fall;

    dtc_sync2 #(.WIDTH(4)) u_in_sync (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .async_in    ({manual_frame_sync_n_in, input_vsync_in, input_hsync_in,
                       input_pixel_clock_in}),
        .sync_out    (sync_lvl),
        .rise_out    (sync_rise),
        .fall_out    (sync_fall)
    );
    assign input_pixel_clock_rise = sync_rise[0];
    assign ip_hs_rise  = sync_rise[1];
    assign ip_vs_rise  = sync_rise[2];
    assign man_fall    = sync_fall[3];

    // Source position counters on input pixel edges
    logic [CNT_W-1:0] src_h_q;
    logic [CNT_W-1:0] src_v_q;
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            src_h_q <= DTC_CNT_RST;
            src_v_q <= DTC_CNT_RST;
        end else if (ip_vs_rise) begin
            src_h_q <= DTC_CNT_RST;
            src_v_q <= DTC_CNT_RST;
        end else if (ip_hs_rise) begin
            src_h_q <= DTC_CNT_RST;
            src_v_q <= src_v_q + 1'b1;
        end else if (input_pixel_clock_rise) begin
            src_h_q <= src_h_q + 1'b1;
        end
    end

    // Closed-loop control word: ratio of display to source frame size
    logic [PROD_W-1:0]     disp_prod;
    logic [PROD_W-1:0]     src_prod;
    logic [FCW_W-1:0]      period_fcw_q;
    logic [FCW_W-1:0]      closed_fcw_q;
    logic [FCW_W+PROD_W-1:0] scaled;
    assign disp_prod = PROD_W'(display_line_total_in * display_frame_lines_in * rate_m_in);
    assign src_prod  = PROD_W'(source_line_total_in * source_frame_lines_in * rate_n_in);

    // Frequency ratio detector: measure input pixel rate per core cycle
    logic [FCW_W-1:0] ip_acc_q;
    logic [7:0]       win_q;
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            ip_acc_q     <= DTC_FCW_RST;
            win_q        <= 8'h00;
            period_fcw_q <= DTC_FCW_RST;
        end else begin
            win_q    <= win_q + 8'h01;
            ip_acc_q <= input_pixel_clock_rise ? ip_acc_q + 1'b1 : ip_acc_q;
            if (win_q == 8'hff) begin
                // Input edges per 256 cycles scaled to full accumulator range
                period_fcw_q <= FCW_W'({ip_acc_q, 22'h000000});
                ip_acc_q     <= DTC_FCW_RST;
            end
        end
    end

    assign scaled = ({{PROD_W{1'b0}}, period_fcw_q} * (FCW_W+PROD_W)'(disp_prod))
                    / ((src_prod == '0) ? (FCW_W+PROD_W)'(1) : (FCW_W+PROD_W)'(src_prod));
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            closed_fcw_q <= DTC_FCW_RST;
        end else begin
            closed_fcw_q <= scaled[FCW_W-1:0];
        end
    end

    // loop select; free-run forces open loop
    logic closed_loop;
    logic pix_tick;
    assign closed_loop = (sync_mode_in == DTC_SYNC_FRAME);

    dtc_display_clock_synthesizer #(.FCW_W(FCW_W)) u_display_clock_synthesizer (
        .core_clk_in    (core_clk_in),
        .rst_b_in       (rst_b_in),
        .closed_loop_in (closed_loop),
        .open_fcw_in    (open_fcw_in),
        .closed_fcw_in  (closed_fcw_q),
        .pix_tick_out   (pix_tick),
        .fcw_out        (active_fcw_out)
    );

    // Lock event detect and every-N counting
    logic             at_event;
    logic             ev_seen_q;
    logic [RATE_W-1:0] frame_cnt_q;
    logic             lock_fire;
    logic             man_pend_q;
    logic             frame_pend_q;
    assign at_event = (src_h_q == lock_event_h_in) && (src_v_q == lock_event_v_in);

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            ev_seen_q   <= 1'b0;
            frame_cnt_q <= DTC_RATE_ONE;
        end else if (ip_vs_rise) begin
            ev_seen_q <= 1'b0;
        end else if (at_event && !ev_seen_q && sync_mode_in == DTC_SYNC_FRAME) begin
            ev_seen_q <= 1'b1;
            if (!frc_en_in || frame_cnt_q >= lock_every_n_in) begin
                frame_cnt_q <= DTC_RATE_ONE;
            end else begin
                frame_cnt_q <= frame_cnt_q + 1'b1;
            end
        end
    end
    assign lock_fire = at_event && !ev_seen_q && sync_mode_in == DTC_SYNC_FRAME
                       && (!frc_en_in || frame_cnt_q >= lock_every_n_in);

    // Pending reloads held until next display pixel tick; set wins over clear
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            frame_pend_q <= 1'b0;
            man_pend_q   <= 1'b0;
        end else begin
            if (lock_fire) begin
                frame_pend_q <= 1'b1;
            end else if (pix_tick) begin
                frame_pend_q <= 1'b0;
            end
            if (manual_sync_en_in && man_fall) begin
                man_pend_q <= 1'b1;
            end else if (pix_tick) begin
                man_pend_q <= 1'b0;
            end
        end
    end

    // counters reload from lock-load; counts from sync lead
    logic [CNT_W-1:0] h_q;
    logic [CNT_W-1:0] v_q;
    logic             reload;
    assign reload = frame_pend_q || man_pend_q;
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            h_q <= DTC_CNT_RST;
            v_q <= DTC_CNT_RST;
        end else if (pix_tick) begin
            if (reload) begin
                h_q <= lock_load_h_in;
                v_q <= lock_load_v_in;
            end else if (h_q + 1'b1 >= display_line_total_in) begin
                h_q <= DTC_CNT_RST;
                v_q <= (v_q + 1'b1 >= display_frame_lines_in) ? DTC_CNT_RST : v_q + 1'b1;
            end else begin
                h_q <= h_q + 1'b1;
            end
        end
    end

    assign double_wide_ok_out = !display_line_total_in[0] && !h_active_start_in[0]
                                && !h_active_end_in[0];

    // Display clock: one core-cycle pulse per tick, every second tick in double-wide mode
    logic display_pixel_clock_q;
    logic wide_phase_q;
    logic launch;
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            display_pixel_clock_q       <= 1'b0;
            wide_phase_q <= 1'b0;
        end else if (pix_tick) begin
            wide_phase_q <= ~wide_phase_q;
            display_pixel_clock_q       <= !double_wide_in || wide_phase_q;
        end else begin
            display_pixel_clock_q <= 1'b0;
        end
    end
    assign launch = pix_tick && (!double_wide_in || wide_phase_q);

    // launched with the display clock; programmed positions
    logic hs_d;
    logic vs_d;
    logic de_d;
    assign hs_d = h_q < hsync_width_in;
    assign vs_d = v_q < vsync_width_in;
    assign de_d = (h_q >= h_active_start_in) && (h_q < h_active_end_in)
                  && (v_q >= v_active_start_in) && (v_q < v_active_end_in);

    // format select; 18-bit keeps upper six bits per channel
    logic [DTC_PIX_W-1:0] fmt_a;
    logic [DTC_PIX_W-1:0] fmt_b;
    always_comb begin
        fmt_a = pixel_a_in;
        fmt_b = pixel_b_in;
        if (fmt_24_in == DTC_FMT_18) begin
            fmt_a = {6'h00, pixel_a_in[23:18], pixel_a_in[15:10], pixel_a_in[7:2]};
            fmt_b = {6'h00, pixel_b_in[23:18], pixel_b_in[15:10], pixel_b_in[7:2]};
        end
    end

    // Output registers
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            display_hsync_out       <= 1'b0;
            display_vsync_out       <= 1'b0;
            display_data_enable_out <= 1'b0;
            display_data_a_out      <= '0;
            display_data_b_out      <= '0;
            lock_applied_out        <= 1'b0;
        end else begin
            lock_applied_out <= pix_tick && reload;
            if (launch) begin
                display_hsync_out       <= hs_d;
                display_vsync_out       <= vs_d;
                display_data_enable_out <= de_d;
                display_data_a_out      <= de_d ? fmt_a : '0;
                display_data_b_out      <= (de_d && double_wide_in && double_wide_ok_out)
                                           ? fmt_b : '0;
            end
        end
    end
    assign display_pixel_clock_out = display_pixel_clock_q;

    // reset mode comes from the free-run encoding of sync_mode_in
    // range limits are for the external multiplier, kept as constants
endmodule : dtc_display_timing
`default_nettype wire

// [test/dtc_display_timing_asserts.sv]
// Port-level checker for the display timing block
`timescale 1ns/1ns
`default_nettype none
module dtc_display_timing_asserts
    import dtc_pkg::*;
#(
    parameter int CNT_W = DTC_CNT_W,
    parameter int FCW_W = DTC_FCW_W
) (
    // Clock, reset and controls
    input wire logic             core_clk_in,
    input wire logic             rst_b_in,
    input wire dtc_sync_mode_t   sync_mode_in,
    input wire logic             manual_sync_en_in,
    input wire logic             fmt_24_in,
    input wire logic [FCW_W-1:0] open_fcw_in,
    input wire logic [CNT_W-1:0] display_line_total_in,
    input wire logic [CNT_W-1:0] hsync_width_in,
    input wire logic [CNT_W-1:0] h_active_start_in,
    input wire logic [CNT_W-1:0] vsync_width_in,
    input wire logic [CNT_W-1:0] lock_load_h_in,
    input wire logic [CNT_W-1:0] lock_load_v_in,
    input wire logic             manual_frame_sync_n_in,
    // Design outputs
    input wire logic             display_pixel_clock_out,
    input wire logic             display_hsync_out,
    input wire logic             display_vsync_out,
    input wire logic             display_data_enable_out,
    input wire logic [23:0]      display_data_a_out,
    input wire logic             double_wide_ok_out,
    input wire logic             lock_applied_out,
    input wire logic [FCW_W-1:0] active_fcw_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_b_in |=> !display_pixel_clock_out && !display_data_enable_out
            && !lock_applied_out && active_fcw_out == '0) else $error("outputs busy after reset");
    a_launch_only: assert property (!display_pixel_clock_out |->
        $stable({display_hsync_out, display_vsync_out, display_data_enable_out}))
        else $error("timing output moved without pixel clock");
    a_de_blank: assert property (display_data_enable_out
        && h_active_start_in >= hsync_width_in |-> !display_hsync_out)
        else $error("data enable during horizontal sync");
    a_free_fcw: assert property ((rst_b_in && sync_mode_in != DTC_SYNC_FRAME
        && $stable(open_fcw_in))[*4] |-> active_fcw_out == open_fcw_in)
        else $error("free-run control word not taken");
    a_no_lock_free: assert property ((sync_mode_in != DTC_SYNC_FRAME
        && !manual_sync_en_in)[*8] |-> !lock_applied_out) else $error("lock in free-run");
    a_manual_lock: assert property ($fell(manual_frame_sync_n_in) && manual_sync_en_in
        |-> ##[2:24] lock_applied_out) else $error("manual sync not applied");
    a_lock_load: assert property (lock_applied_out && lock_load_h_in == '0
        && lock_load_v_in == '0 && hsync_width_in != '0 && vsync_width_in != '0
        |-> ##[1:24] (display_pixel_clock_out && display_hsync_out && display_vsync_out))
        else $error("lock load position not shown");
    a_dw_odd: assert property (display_line_total_in[0] || h_active_start_in[0]
        |-> !double_wide_ok_out) else $error("double-wide allowed with odd count");
    a_fmt18_top: assert property (display_pixel_clock_out && !fmt_24_in
        && !$past(fmt_24_in) |-> display_data_a_out[23:18] == 6'h00)
        else $error("18-bit word has upper bits set");

    c_lock: cover property (lock_applied_out);
    c_manual: cover property ($fell(manual_frame_sync_n_in) && manual_sync_en_in);
    c_dw_de: cover property (double_wide_ok_out && display_data_enable_out);
endmodule : dtc_display_timing_asserts

bind dtc_display_timing dtc_display_timing_asserts #(.CNT_W(CNT_W), .FCW_W(FCW_W)) u_asserts (.*);
`default_nettype wire

// [test/dtc_panel_model.sv]
// Flat panel model: measures each frame seen on the display port
`timescale 1ns/1ns
`default_nettype none
module dtc_panel_model (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    // Display port
    input  wire logic        pix_clk_in,
    input  wire logic        hsync_in,
    input  wire logic        vsync_in,
    input  wire logic        de_in,
    input  wire logic [23:0] data_in,
    // Figures of the last whole frame
    output logic      [15:0] frames_out,
    output logic      [15:0] ticks_out,
    output logic      [15:0] de_count_out,
    output logic      [15:0] hs_count_out,
    output logic      [15:0] vs_count_out,
    output logic      [15:0] de_offset_out,
    output logic      [23:0] data_out
);
    logic [15:0] ticks_q, de_q, hs_q, vs_q, pos_q;
    logic        hs_d1_q, vs_d1_q, de_d1_q;
    // panel samples on pixel clock only
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            {frames_out, ticks_out, de_count_out, hs_count_out, vs_count_out} <= '0;
            {de_offset_out, data_out, ticks_q, de_q, hs_q, vs_q, pos_q} <= '0;
            {hs_d1_q, vs_d1_q, de_d1_q} <= '0;
        end else if (pix_clk_in) begin
            {hs_d1_q, vs_d1_q, de_d1_q} <= {hsync_in, vsync_in, de_in};
            pos_q <= (hsync_in && !hs_d1_q) ? 16'h0001 : pos_q + 16'h0001;
            if (de_in && !de_d1_q) de_offset_out <= pos_q;
            if (de_in) data_out <= data_in;
            if (vsync_in && !vs_d1_q) begin
                frames_out <= frames_out + 16'h0001;
                {ticks_out, de_count_out, hs_count_out, vs_count_out} <= {ticks_q, de_q, hs_q, vs_q};
                {ticks_q, vs_q} <= {16'h0001, 16'h0001};
                {de_q, hs_q} <= {15'h0000, de_in, 15'h0000, hsync_in};
            end else begin
                ticks_q <= ticks_q + 16'h0001;
                de_q <= de_q + {15'h0000, de_in};
                hs_q <= hs_q + {15'h0000, hsync_in};
                vs_q <= vs_q + {15'h0000, vsync_in};
            end
        end
    end
endmodule : dtc_panel_model
`default_nettype wire

// [test/dtc_display_timing_tb.sv]
// Self-checking bench for the display timing block
`timescale 1ns/1ns
`default_nettype none
module dtc_display_timing_tb;
    import dtc_pkg::*;
    logic           core_clk_in = 1'b0, rst_b_in = 1'b0, input_pixel_clock = 1'b0, ip_hs = 1'b0, ip_vs = 1'b0;
    dtc_sync_mode_t mode = DTC_SYNC_FREE_RUN;
    logic           man_en = 1'b0, frc = 1'b0, f24 = 1'b1, dw = 1'b0, man_n = 1'b1;
    logic [7:0]     every_n = 8'h01;
    logic [29:0]    ofcw = 30'h2000_0000;
    logic [11:0]    lt = 12'h010, fl = 12'h008, hw = 12'h002, has = 12'h004, hae = 12'h00c;
    logic [11:0]    vw = 12'h001, vas = 12'h002, vae = 12'h006, sh = 12'h000, sv = 12'h000;
    logic [23:0]    pa = 24'h000000, pb = 24'h000000, da, db, p_data;
    logic           pclk, hs, vs, de, dw_ok, lock;
    logic [29:0]    fcw;
    logic [15:0]    p_frames, p_ticks, p_de, p_hs, p_vs, p_off;
    int             bad_count = 0, samples_checked = 0, locks = 0, cycles = 0, n0;

    dtc_display_timing u_dtc_display_timing (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .sync_mode_in(mode), .manual_sync_en_in(man_en), .frc_en_in(frc),
        .lock_every_n_in(every_n), .fmt_24_in(f24), .double_wide_in(dw), .open_fcw_in(ofcw),
        .rate_m_in(8'h01), .rate_n_in(8'h01), .source_line_total_in(lt),
        .source_frame_lines_in(fl), .display_line_total_in(lt), .display_frame_lines_in(fl),
        .hsync_width_in(hw), .h_active_start_in(has), .h_active_end_in(hae), .vsync_width_in(vw),
        .v_active_start_in(vas), .v_active_end_in(vae), .lock_event_h_in(has),
        .lock_event_v_in(vas), .lock_load_h_in(12'h000), .lock_load_v_in(12'h000),
        .input_pixel_clock_in(input_pixel_clock), .input_hsync_in(ip_hs), .input_vsync_in(ip_vs),
        .manual_frame_sync_n_in(man_n), .pixel_a_in(pa), .pixel_b_in(pb),
        .display_pixel_clock_out(pclk), .display_hsync_out(hs), .display_vsync_out(vs),
        .display_data_enable_out(de), .display_data_a_out(da), .display_data_b_out(db),
        .double_wide_ok_out(dw_ok), .lock_applied_out(lock), .active_fcw_out(fcw));
    dtc_panel_model u_dtc_panel_model (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .pix_clk_in(pclk), .hsync_in(hs), .vsync_in(vs), .de_in(de), .data_in(da),
        .frames_out(p_frames), .ticks_out(p_ticks), .de_count_out(p_de), .hs_count_out(p_hs),
        .vs_count_out(p_vs), .de_offset_out(p_off), .data_out(p_data));

    always #25 core_clk_in = ~core_clk_in;
    // Source timing, 16 pixels by 8 lines, free-running 400 ns pixel clock
    always #200 input_pixel_clock = ~input_pixel_clock;
    always @(posedge input_pixel_clock) begin
        sh <= (sh == 12'h00f) ? 12'h000 : sh + 12'h001;
        if (sh == 12'h00f) sv <= (sv == 12'h007) ? 12'h000 : sv + 12'h001;
        ip_hs <= (sh < 12'h002);
        ip_vs <= (sv == 12'h000);
    end
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (lock === 1'b1) locks <= locks + 1;
        if (cycles == 60000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (bad_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic cyc(int n);
        repeat (n) @(posedge core_clk_in);
        #2;
    endtask : cyc
    task automatic restart();
        rst_b_in = 1'b0;
        cyc(4);
        rst_b_in = 1'b1;
    endtask : restart
    task automatic manual_pulse(logic en, int exp);
        man_en = en;
        n0 = locks;
        // active-low manual frame sync from outside
        man_n = 1'b0;
        cyc(4);
        man_n = 1'b1;
        cyc(30);
        check("manual lock count", locks - n0, exp);
    endtask : manual_pulse
    function automatic logic [23:0] fmt_exp(logic [23:0] a, logic w24);
        return w24 ? a : {6'h00, a[23:18], a[15:10], a[7:2]};
    endfunction : fmt_exp

    initial begin
        void'($urandom(25));
        cyc(15);
        check("clock during reset", pclk, 1'b0);
        check("fcw during reset", fcw, 30'h0);
        cyc(1);
        rst_b_in = 1'b1;
        for (int i = 0; i < 4; i++) begin
            lt = 12'h010 + 12'(2 * ($urandom % 8));
            fl = 12'h008 + 12'($urandom % 4);
            hw = 12'h001 + 12'($urandom % 3);
            has = hw + 12'($urandom % 3);
            hae = lt - 12'($urandom % 3);
            vw = 12'h001 + 12'($urandom % 2);
            vas = vw + 12'($urandom % 2);
            vae = fl - 12'($urandom % 2);
            f24 = (i == 0) ? 1'b0 : 1'($urandom);
            pa = 24'($urandom);
            ofcw = 30'h1000_0000 + 30'($urandom % 32'h1000_0000);
            restart();
            while (p_frames < 16'h0003) cyc(1);
            check("frame ticks", p_ticks, lt * fl);
            check("de count", p_de, (hae - has) * (vae - vas));
            check("hsync count", p_hs, hw * fl);
            check("vsync count", p_vs, vw * lt);
            check("de offset", p_off, has);
            check("pixel word", p_data, fmt_exp(pa, f24));
            check("free fcw", fcw, ofcw);
            check("free no lock", locks, 0);
        end
        {lt, hw, has, hae, f24, dw, pb} = {12'h010, 12'h002, 12'h004, 12'h00c, 2'b11, 24'($urandom)};
        restart();
        cyc(1);
        check("double ok even", dw_ok, 1'b1);
        while (!(pclk === 1'b1 && de === 1'b1)) cyc(1);
        check("double a", da, pa);
        check("double b", db, pb);
        has = 12'h005;
        #1;
        check("double ok odd", dw_ok, 1'b0);
        {has, dw} = {12'h004, 1'b0};
        manual_pulse(1'b1, 1);
        manual_pulse(1'b0, 0);
        {lt, fl, vw, vas, vae} = {12'h010, 12'h008, 12'h001, 12'h002, 12'h006};
        mode = DTC_SYNC_FRAME;
        restart();
        cyc(3000);
        check("closed fcw", (fcw > 30'h0780_0000 && fcw < 30'h0880_0000), 1);
        n0 = locks;
        cyc(4096);
        check("locks per frame", locks - n0, 4);
        {frc, every_n} = {1'b1, 8'h03};
        cyc(3072);
        n0 = locks;
        cyc(6144);
        check("locks every third", locks - n0, 2);
        stop_test();
    end
endmodule : dtc_display_timing_tb
`default_nettype wire
